// ### include/ext_exec_pkg.sv
// Purpose: Shared constants, opcodes and decode helpers for the extended executor
// Assumes: 8-bit data path, flags held in one status byte
// Notes:   Unused opcode values are illegal and fall back to idle behaviour
package ext_exec_pkg;

	// ****************************************
	// Widths, addresses and reset values
	// ****************************************
	localparam int         DM_AW_DEF    = 10;
	localparam int         PM_AW_DEF    = 14;
	localparam logic [9:0] PC_LOW_ADDR  = 10'h006;
	localparam logic [9:0] TBL_PTR_ADDR = 10'h007;
	localparam logic [7:0] ACC_RST      = 8'h00;
	localparam logic [7:0] STATUS_RST   = 8'h00;
	localparam logic [7:0] TP_RST       = 8'h00;
	localparam logic [3:0] BCD_MAX      = 4'h9;
	localparam logic [3:0] BCD_ADJ      = 4'h6;

	// ****************************************
	// Status bit positions and check masks
	// ****************************************
	localparam int         FLG_Z   = 0;
	localparam int         FLG_C   = 1;
	localparam int         FLG_HB  = 2;
	localparam int         FLG_SW  = 3;
	localparam int         FLG_SR  = 4;
	localparam int         FLG_ZC  = 5;
	localparam int         FLG_WE  = 6;
	localparam int         FLG_PD  = 7;
	localparam logic [7:0] KEEP_EXCEPT_Z = 8'h3E;
	localparam logic [7:0] KEEP_EXCEPT_C = 8'h3D;

	// ****************************************
	// Operations
	// ****************************************
	typedef enum logic [5:0] {
		op_add, op_adc, op_sub, op_sbc, op_add_imm, op_and_imm, decimal_adjust_op,
		op_and, op_or, op_xor, invert_memory_op, op_inc, op_dec,
		op_rr, op_rrc, op_rl, op_rlc, op_mov_ld, op_mov_st, op_bit_clr, op_bit_set,
		op_sz, op_sza, op_snz, op_szb, op_snzb, op_siz, op_sdz,
		far_table_read_op, far_last_table_read_op, far_preinc_table_read_op,
		far_preinc_last_table_read_op, op_clr, op_set, op_swap, op_call, op_wdt_clr
	} op_e;

	function automatic logic is_skip(op_e op);
		return op inside {op_sz, op_sza, op_snz, op_szb, op_snzb, op_siz, op_sdz};
	endfunction

	function automatic logic is_table(op_e op);
		return op inside {far_table_read_op, far_last_table_read_op,
			far_preinc_table_read_op, far_preinc_last_table_read_op};
	endfunction

	function automatic logic is_preinc(op_e op);
		return op inside {far_preinc_table_read_op, far_preinc_last_table_read_op};
	endfunction

	function automatic logic is_last_page(op_e op);
		return op inside {far_last_table_read_op, far_preinc_last_table_read_op};
	endfunction

	function automatic logic is_zero_only(op_e op);
		return op inside {op_and, op_and_imm, op_or, op_xor, invert_memory_op, op_inc, op_dec};
	endfunction

	function automatic logic uses_imm(op_e op);
		return op inside {op_add_imm, op_and_imm};
	endfunction

	// Ops whose destination bit picks accumulator or memory
	function automatic logic dest_form(op_e op);
		return op inside {op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor,
			invert_memory_op, op_inc, op_dec, op_rr, op_rrc, op_rl, op_rlc, op_swap,
			op_siz, op_sdz};
	endfunction

	function automatic logic writes_mem(op_e op, logic dest_acc);
		if (dest_form(op))
			return !dest_acc;
		return is_table(op) || (op inside {decimal_adjust_op, op_mov_st, op_bit_clr,
			op_bit_set, op_clr, op_set});
	endfunction

	function automatic logic writes_acc(op_e op, logic dest_acc);
		if (dest_form(op))
			return dest_acc;
		return op inside {op_mov_ld, op_sza, op_add_imm, op_and_imm};
	endfunction

endpackage

// ### core/ext_alu.sv
// Purpose: Combinational result, flag and skip logic for one operation
// Assumes: Operand m is already chosen between memory data and immediate
// Notes:   Flags not touched by an operation pass through unchanged
module ext_alu (
	input  wire ext_exec_pkg::op_e op,
	input  wire logic [7:0]        a,
	input  wire logic [7:0]        m,
	input  wire logic [2:0]        bsel,
	input  wire logic [7:0]        flags_in,
	output logic [7:0]             res,
	output logic [7:0]             flags_out,
	output logic                   skip
);
	import ext_exec_pkg::*;

	logic [7:0] mm;
	logic       cin;
	logic [8:0] sum;
	logic [4:0] half;
	logic       lo_adj;
	logic       hi_adj;

	// One case per operation group, unlisted ops take the default, flags default to unchanged
	always_comb
	begin
		mm = m;
		cin = 1'b0;
		sum = 9'h000;
		half = 5'h00;
		lo_adj = 1'b0;
		hi_adj = 1'b0;
		res = m;
		flags_out = flags_in;
		skip = 1'b0;
		unique case (op)
			op_add, op_adc, op_add_imm, op_sub, op_sbc:
			begin
				if (op inside {op_sub, op_sbc})
					mm = ~m;
				cin = (op == op_sub) | ((op inside {op_adc, op_sbc}) & flags_in[FLG_C]);
				sum = {1'b0, a} + {1'b0, mm} + {8'h00, cin};
				half = {1'b0, a[3:0]} + {1'b0, mm[3:0]} + {4'h0, cin};
				res = sum[7:0];
				flags_out[FLG_C] = sum[8];
				flags_out[FLG_HB] = half[4];
				flags_out[FLG_SW] = (a[7] == mm[7]) & (res[7] != a[7]);
				flags_out[FLG_Z] = (res == 8'h00);
				flags_out[FLG_SR] = res[7] ^ flags_out[FLG_SW];
				if (op == op_sub)
					flags_out[FLG_ZC] = flags_out[FLG_Z];
				else if (op == op_sbc)
					flags_out[FLG_ZC] = flags_out[FLG_Z] & flags_in[FLG_ZC];
			end
			decimal_adjust_op:
			begin
				lo_adj = (a[3:0] > BCD_MAX) | flags_in[FLG_HB];
				hi_adj = (a[7:4] > BCD_MAX) | flags_in[FLG_C];
				sum = {1'b0, a} + {1'b0, hi_adj ? BCD_ADJ : 4'h0, lo_adj ? BCD_ADJ : 4'h0};
				res = sum[7:0];
				flags_out[FLG_C] = sum[8] | flags_in[FLG_C];
			end
			op_and, op_and_imm: res = a & m;
			op_or:              res = a | m;
			op_xor:             res = a ^ m;
			invert_memory_op:   res = ~m;
			op_inc:             res = m + 8'h01;
			op_dec:             res = m - 8'h01;
			op_rr:              res = {m[0], m[7:1]};
			op_rl:              res = {m[6:0], m[7]};
			op_rrc:
			begin
				res = {flags_in[FLG_C], m[7:1]};
				flags_out[FLG_C] = m[0];
			end
			op_rlc:
			begin
				res = {m[6:0], flags_in[FLG_C]};
				flags_out[FLG_C] = m[7];
			end
			op_mov_st:          res = a;
			op_bit_clr:         res = m & ~(8'h01 << bsel);
			op_bit_set:         res = m | (8'h01 << bsel);
			op_sz, op_sza:      skip = (m == 8'h00);
			op_snz:             skip = (m != 8'h00);
			op_szb:             skip = !m[bsel];
			op_snzb:            skip = m[bsel];
			op_siz:
			begin
				res = m + 8'h01;
				skip = (res == 8'h00);
			end
			op_sdz:
			begin
				res = m - 8'h01;
				skip = (res == 8'h00);
			end
			op_clr:             res = 8'h00;
			op_set:             res = 8'hFF;
			op_swap:            res = {m[3:0], m[7:4]};
			default:            res = m;
		endcase
		if (is_zero_only(op))
			flags_out[FLG_Z] = (res == 8'h00);
	end

endmodule // ext_alu

// ### core/ext_instr_exec.sv
// Purpose: Sequencer for extended instructions with full-range data addressing
// Assumes: Data and program memory answer a read while the registered strobe stands
// Notes:   An issue while busy is ignored; the fetch unit waits for done
// Contract
// - Extended operands reach any data sector directly, no pointer indirection.
// - Plain extended operations without skip, table read or low-PC write finish in 2 cycles.
// - Table reads take 3 cycles, load high byte register and memory.
// - Extended skip takes 3 cycles when skipping, 2 otherwise.
// - Writing the low program counter byte makes the instruction 3 cycles.
// - Adds update five flags, subtracts add zero-chain, decimal adjust only carry.
// - Logic, invert, inc, dec touch zero only; rotates as documented.
// - Add with carry sums accumulator, operand and carry.
// - Add sums accumulator with operand or immediate.
// - AND combines accumulator with operand or immediate, zero flag only.
// - Call pushes next address, loads target, two cycles, no flags.
// - Clear writes 00H; bit clear drops one bit; no flags.
// - Watchdog clear resets the counter, expired bit and power-down bit.
// - Invert complements operand; accumulator form leaves memory alone.
// - Decimal adjust adds 6 per nibble above 9 or with carry.
// - Decimal adjust changes only carry, marking a sum of 100 or more.
module ext_instr_exec #(
	parameter int DM_AW = ext_exec_pkg::DM_AW_DEF,
	parameter int PM_AW = ext_exec_pkg::PM_AW_DEF
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              issue_valid,
	input  wire ext_exec_pkg::op_e issue_op,
	input  wire logic [DM_AW-1:0]  issue_addr,
	input  wire logic              issue_dest_acc,
	input  wire logic [2:0]        issue_bit,
	input  wire logic [7:0]        issue_imm,
	input  wire logic [PM_AW-1:0]  call_target,
	input  wire logic [PM_AW-9:0]  table_page,
	input  wire logic              wdt_timeout,
	input  wire logic              power_down_set,
	input  wire logic [7:0]        mem_rd_data,
	input  wire logic [15:0]       prog_rd_data,
	output logic                   busy,
	output logic                   done,
	output logic                   skip_taken,
	output logic                   mem_rd_en,
	output logic                   mem_wr_en,
	output logic [DM_AW-1:0]       mem_addr,
	output logic [7:0]             mem_wr_data,
	output logic                   prog_rd_en,
	output logic [PM_AW-1:0]       prog_rd_addr,
	output logic                   stack_push,
	output logic [PM_AW-1:0]       stack_data,
	output logic                   wdt_clear,
	output logic [7:0]             acc,
	output logic [7:0]             status,
	output logic [PM_AW-1:0]       pc,
	output logic [7:0]             table_pointer,
	output logic [7:0]             table_high_byte
);
	import ext_exec_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {ph_idle, ph_read, ph_tail} phase_e;

	typedef struct packed {
		phase_e           phase;
		op_e              op;
		logic             dest;
		logic [7:0]       imm;
		logic [2:0]       bsel;
		logic [DM_AW-1:0] addr;
		logic             skip;
		logic             pc_set;
		logic             busy;
		logic             done;
		logic             skip_taken;
		logic             mem_rd_en;
		logic             mem_wr_en;
		logic [7:0]       mem_wr_data;
		logic             prog_rd_en;
		logic [PM_AW-1:0] prog_addr;
		logic             stack_push;
		logic [PM_AW-1:0] stack_data;
		logic             wdt_clear;
		logic [7:0]       acc;
		logic [7:0]       status;
		logic [PM_AW-1:0] pc;
		logic [7:0]       tp;
		logic [7:0]       tbl_high;
	} st_s;

	localparam logic [DM_AW-1:0] PCL_A = DM_AW'(PC_LOW_ADDR);
	localparam logic [DM_AW-1:0] TP_A  = DM_AW'(TBL_PTR_ADDR);

	st_s        s_r;
	st_s        s_nxt;
	logic [7:0] m_val;
	logic [7:0] alu_res;
	logic [7:0] alu_flags;
	logic       alu_skip;
	logic [7:0] wdata;
	logic [7:0] tp_eff;
	logic       wmem;
	logic       finish;
	logic       take;

	// ****************************************
	// Operand path
	// ****************************************
	// immediate operand select
	assign m_val = uses_imm(s_r.op) ? s_r.imm : mem_rd_data;
	assign take  = (s_r.phase == ph_idle) && issue_valid;

	ext_alu u_alu (
		.op        (s_r.op),
		.a         (s_r.acc),
		.m         (m_val),
		.bsel      (s_r.bsel),
		.flags_in  (s_r.status),
		.res       (alu_res),
		.flags_out (alu_flags),
		.skip      (alu_skip)
	);

	// ****************************************
	// Next state
	// ****************************************
	// Pulses drop each cycle; the case sets what this cycle needs
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.skip_taken = 1'b0;
		s_nxt.mem_rd_en = 1'b0;
		s_nxt.mem_wr_en = 1'b0;
		s_nxt.prog_rd_en = 1'b0;
		s_nxt.stack_push = 1'b0;
		s_nxt.wdt_clear = 1'b0;
		finish = 1'b0;
		wmem = writes_mem(s_r.op, s_r.dest);
		wdata = is_table(s_r.op) ? prog_rd_data[7:0] : alu_res;
		tp_eff = s_r.tp + {7'h00, is_preinc(issue_op)};
		unique case (s_r.phase)
			ph_idle:
			begin
				if (issue_valid)
				begin
					s_nxt.addr = issue_addr;
					s_nxt.op = issue_op;
					s_nxt.dest = issue_dest_acc;
					s_nxt.imm = issue_imm;
					s_nxt.bsel = issue_bit;
					s_nxt.skip = 1'b0;
					s_nxt.pc_set = 1'b0;
					s_nxt.busy = 1'b1;
					s_nxt.mem_rd_en = 1'b1;
					s_nxt.phase = ph_read;
					if (is_table(issue_op))
					begin
						s_nxt.tp = tp_eff;
						s_nxt.prog_rd_en = 1'b1;
						if (is_last_page(issue_op))
							s_nxt.prog_addr = {{(PM_AW-8){1'b1}}, tp_eff};
						else
							s_nxt.prog_addr = {table_page, tp_eff};
					end
					if (issue_op == op_call)
					begin
						s_nxt.stack_push = 1'b1;
						s_nxt.stack_data = s_r.pc + {{(PM_AW-1){1'b0}}, 1'b1};
						s_nxt.pc = call_target;
						s_nxt.pc_set = 1'b1;
					end
					if (issue_op == op_wdt_clr)
					begin
						s_nxt.wdt_clear = 1'b1;
						s_nxt.status[FLG_WE] = 1'b0;
						s_nxt.status[FLG_PD] = 1'b0;
					end
				end
			end
			ph_read:
			begin
				s_nxt.status[FLG_ZC:FLG_Z] = alu_flags[FLG_ZC:FLG_Z];
				if (writes_acc(s_r.op, s_r.dest))
					s_nxt.acc = alu_res;
				if (is_table(s_r.op))
					s_nxt.tbl_high = prog_rd_data[15:8];
				if (wmem)
				begin
					s_nxt.mem_wr_en = 1'b1;
					s_nxt.mem_wr_data = wdata;
					if (s_r.addr == TP_A)
						s_nxt.tp = wdata;
					if (s_r.addr == PCL_A)
					begin
						s_nxt.pc[7:0] = wdata;
						s_nxt.pc_set = 1'b1;
					end
				end
				s_nxt.skip = is_skip(s_r.op) && alu_skip;
				if (is_table(s_r.op) || s_nxt.skip || (wmem && s_r.addr == PCL_A))
					s_nxt.phase = ph_tail;
				else
					finish = 1'b1;
			end
			ph_tail:
			begin
				finish = 1'b1;
				s_nxt.skip_taken = s_r.skip;
			end
			default:
			begin
				s_nxt.phase = ph_idle;
				s_nxt.busy = 1'b0;
			end
		endcase
		if (finish)
		begin
			s_nxt.phase = ph_idle;
			s_nxt.busy = 1'b0;
			s_nxt.done = 1'b1;
			if (!s_nxt.pc_set)
				s_nxt.pc = s_r.pc + {{(PM_AW-2){1'b0}}, s_r.skip | s_nxt.skip, ~(s_r.skip | s_nxt.skip)};
		end
		// Hardware events win over a clear in the same cycle
		if (wdt_timeout)
			s_nxt.status[FLG_WE] = 1'b1;
		if (power_down_set)
			s_nxt.status[FLG_PD] = 1'b1;
	end

	// Single register stage for the whole state
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_r <= '0;
			s_r.acc <= ACC_RST;
			s_r.status <= STATUS_RST;
			s_r.tp <= TP_RST;
		end
		else
			s_r <= s_nxt;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign busy            = s_r.busy;
	assign done            = s_r.done;
	assign skip_taken      = s_r.skip_taken;
	assign mem_rd_en       = s_r.mem_rd_en;
	assign mem_wr_en       = s_r.mem_wr_en;
	assign mem_addr        = s_r.addr;
	assign mem_wr_data     = s_r.mem_wr_data;
	assign prog_rd_en      = s_r.prog_rd_en;
	assign prog_rd_addr    = s_r.prog_addr;
	assign stack_push      = s_r.stack_push;
	assign stack_data      = s_r.stack_data;
	assign wdt_clear       = s_r.wdt_clear;
	assign acc             = s_r.acc;
	assign status          = s_r.status;
	assign pc              = s_r.pc;
	assign table_pointer   = s_r.tp;
	assign table_high_byte = s_r.tbl_high;

	// ****************************************
	// Checks
	// ****************************************
	// two-cycle timing
	a_plain_two_cycles:
	assert property (@(posedge clock) disable iff (sys_rst)
		take && !is_skip(issue_op) && !is_table(issue_op)
		&& !(writes_mem(issue_op, issue_dest_acc) && issue_addr == PCL_A) |-> ##1 !done ##1 done)
	else $error("plain op did not finish in two cycles");
	a_table_three_cycles:
	assert property (@(posedge clock) disable iff (sys_rst)
		take && is_table(issue_op) |-> ##1 !done ##1 !done ##1 done)
	else $error("table read did not finish in three cycles");
	a_table_word_load:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && is_table(s_r.op)
		|=> mem_wr_en && {table_high_byte, mem_wr_data} == $past(prog_rd_data))
	else $error("table word not loaded to high byte and memory");
	a_preinc_pointer:
	assert property (@(posedge clock) disable iff (sys_rst)
		take && is_preinc(issue_op)
		|=> table_pointer == $past(table_pointer) + 8'h01 && prog_rd_addr[7:0] == table_pointer)
	else $error("pointer not advanced before table read");
	a_skip_taken_cyc:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && is_skip(s_r.op) && alu_skip
		|-> ##1 !done ##1 (done && skip_taken))
	else $error("taken skip not three cycles");
	a_skip_none_cyc:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && is_skip(s_r.op) && !alu_skip |=> done && !skip_taken)
	else $error("untaken skip not two cycles");
	a_pcl_three_cycles:
	assert property (@(posedge clock) disable iff (sys_rst)
		take && writes_mem(issue_op, issue_dest_acc) && issue_addr == PCL_A
		|-> ##1 !done ##1 !done ##1 done)
	else $error("low counter write not three cycles");
	a_call_push_load:
	assert property (@(posedge clock) disable iff (sys_rst)
		take && issue_op == op_call
		|=> stack_push && stack_data == $past(pc) + 1'b1 && pc == $past(call_target)
		##1 done && pc == $past(call_target, 2))
	else $error("call push or target wrong");
	a_wdt_clear_bits:
	assert property (@(posedge clock) disable iff (sys_rst)
		take && issue_op == op_wdt_clr && !wdt_timeout && !power_down_set
		|=> wdt_clear && !status[FLG_WE] && !status[FLG_PD])
	else $error("watchdog clear left flags set");
	a_clear_writes_zero:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && s_r.op == op_clr
		|=> mem_wr_en && mem_wr_data == 8'h00 && status[5:0] == $past(status[5:0]))
	else $error("clear wrote nonzero or changed flags");
	a_decimal_carry_only:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && s_r.op == decimal_adjust_op
		|=> ((status ^ $past(status)) & KEEP_EXCEPT_C) == 8'h00 && mem_wr_en)
	else $error("decimal adjust changed a flag other than carry");
	a_logic_zero_only:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && is_zero_only(s_r.op)
		|=> ((status ^ $past(status)) & KEEP_EXCEPT_Z) == 8'h00)
	else $error("logic op changed a flag other than zero");
	a_invert_to_acc:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && s_r.op == invert_memory_op && s_r.dest
		|=> acc == ~$past(mem_rd_data) && !mem_wr_en)
	else $error("invert to accumulator wrong");
	a_add_to_acc:
	assert property (@(posedge clock) disable iff (sys_rst)
		s_r.phase == ph_read && s_r.op == op_add && s_r.dest
		|=> acc == $past(acc) + $past(mem_rd_data))
	else $error("add result wrong");
endmodule // ext_instr_exec

// ### testbench/ext_mem_model.sv
// Purpose: Data memory, program memory and return stack beside the executor
// Assumes: Both memories answer combinationally while the registered strobe stands
// Notes:   Idle read lines show the inverse so stale data never looks valid
module ext_mem_model (
	input  wire logic        clock,
	input  wire logic        mem_rd_en,
	input  wire logic        mem_wr_en,
	input  wire logic [9:0]  mem_addr,
	input  wire logic [7:0]  mem_wr_data,
	input  wire logic        prog_rd_en,
	input  wire logic [13:0] prog_rd_addr,
	input  wire logic        stack_push,
	input  wire logic [13:0] stack_data,
	output logic      [7:0]  mem_rd_data,
	output logic      [15:0] prog_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  ram [1024];
	logic [13:0] top;

	// ****************************************
	// Memories and stack
	// ****************************************
	// whole address range
	// Program word echoes its address so page and pointer are visible
	always @(posedge clock)
	begin
		if (mem_wr_en)
			ram[mem_addr] <= mem_wr_data;
		if (stack_push)
			top <= stack_data;
	end

	// The executor consumes read data in the strobe cycle itself
	assign mem_rd_data  = mem_rd_en ? ram[mem_addr] : ~ram[mem_addr];
	assign prog_rd_data = prog_rd_en ? {2'b00, prog_rd_addr} : ~{2'b00, prog_rd_addr};
endmodule // ext_mem_model

// ### testbench/mcu_extended_instr_exec_tb_top.sv
// Purpose: Self-checking bench for the extended instruction executor
// Assumes: Flags and memory start from reset values
// Notes:   Scenarios run in order; later ones rely on earlier flag state
module mcu_extended_instr_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ext_exec_pkg::*;
	logic        clock = 1'b0, sys_rst = 1'b1, issue_valid = 1'b0, issue_dest_acc = 1'b0;
	logic        wdt_timeout = 1'b0, power_down_set = 1'b0, sk, wseen;
	op_e         issue_op = op_add;
	logic [9:0]  issue_addr = 10'h000, mem_addr;
	logic [2:0]  issue_bit = 3'h0;
	logic [7:0]  issue_imm = 8'h00, mem_wr_data, mem_rd_data, acc, status;
	logic [7:0]  table_pointer, table_high_byte;
	logic [13:0] call_target = 14'h0000, prog_rd_addr, stack_data, pc, pc0;
	logic [5:0]  table_page = 6'h00;
	logic [15:0] prog_rd_data;
	logic        busy, done, skip_taken, mem_rd_en, mem_wr_en, prog_rd_en, stack_push;
	logic        wdt_clear;
	int          bad_count = 0, n_tests = 0, n;

	// ****************************************
	// Clock, design and memories
	// ****************************************
	always #12.5 clock = ~clock;
	always @(posedge clock)
		if (wdt_clear === 1'b1)
			wseen <= 1'b1;
	ext_instr_exec u_dut (.clock, .sys_rst, .issue_valid, .issue_op, .issue_addr,
		.issue_dest_acc, .issue_bit, .issue_imm, .call_target, .table_page, .wdt_timeout,
		.power_down_set, .mem_rd_data, .prog_rd_data, .busy, .done, .skip_taken,
		.mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data, .prog_rd_en, .prog_rd_addr,
		.stack_push, .stack_data, .wdt_clear, .acc, .status, .pc, .table_pointer,
		.table_high_byte);
	ext_mem_model u_mem (.clock, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data,
		.prog_rd_en, .prog_rd_addr, .stack_push, .stack_data, .mem_rd_data, .prog_rd_data);

	// ****************************************
	// Shared tasks
	// ****************************************
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// Issue one operation, count cycles from the take edge to done
	task run(input op_e o, input logic [9:0] ad, input logic da);
		@(posedge clock);
		issue_op <= o;
		issue_addr <= ad;
		issue_dest_acc <= da;
		issue_valid <= 1'b1;
		@(posedge clock);
		issue_valid <= 1'b0;
		n = 1;
		sk = 1'b0;
		while (n < 8 && done !== 1'b1)
		begin
			@(posedge clock);
			#1;
			n++;
			sk = skip_taken;
		end
		if (done !== 1'b1)
		begin
			bad_count++;
			$display("wrong value at %0t: no done", $time);
		end
		// Let a write issued in the done cycle land in the model
		@(posedge clock);
		#1;
	endtask

	task load(input logic [9:0] ad, input logic [7:0] v);
		u_mem.ram[ad] = v;
		run(op_mov_ld, ad, 1'b0);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_add;
		load(10'h2A5, 8'h3C);
		run(op_add, 10'h2A5, 1'b1);
		chk(16'(n), 16'd2, "add cycles");
		chk(acc, 8'h78, "add sum");
		chk(status, 8'h04, "add flags");
		load(10'h310, 8'hC8);
		run(op_add, 10'h310, 1'b0);
		chk(u_mem.ram[10'h310], 8'h90, "add to memory");
		chk(status, 8'h16, "carry flags");
		chk(acc, 8'hC8, "acc kept");
		u_mem.ram[10'h311] = 8'h01;
		run(op_adc, 10'h311, 1'b1);
		chk(acc, 8'hCA, "adc sum");
		chk(status, 8'h10, "adc flags");
	endtask

	task t_logic;
		issue_imm <= 8'h0F;
		run(op_and_imm, 10'h000, 1'b1);
		chk(acc, 8'h0A, "and imm");
		chk(status, 8'h10, "and flags");
		issue_imm <= 8'h50;
		run(op_and_imm, 10'h000, 1'b1);
		chk(status, 8'h11, "and zero");
		u_mem.ram[10'h120] = 8'h55;
		run(invert_memory_op, 10'h120, 1'b1);
		chk(acc, 8'hAA, "invert acc");
		chk(u_mem.ram[10'h120], 8'h55, "invert mem kept");
		chk(status, 8'h10, "invert zero");
	endtask

	task t_daa;
		load(10'h0A0, 8'hA5);
		run(decimal_adjust_op, 10'h0A0, 1'b0);
		chk(u_mem.ram[10'h0A0], 8'h05, "adjust high");
		chk(status, 8'h12, "adjust carry");
		load(10'h0A1, 8'h9A);
		run(decimal_adjust_op, 10'h0A1, 1'b0);
		chk(u_mem.ram[10'h0A1], 8'h00, "adjust both");
		chk(acc, 8'h9A, "adjust acc kept");
	endtask

	task t_skip;
		u_mem.ram[10'h150] = 8'h00;
		pc0 = pc;
		run(op_sz, 10'h150, 1'b0);
		chk({sk, 15'(n)}, 16'h8003, "skip taken");
		chk(pc, pc0 + 14'd2, "skip pc");
		run(op_snz, 10'h150, 1'b0);
		chk({sk, 15'(n)}, 16'h0002, "no skip");
		chk(pc, pc0 + 14'd3, "no skip pc");
	endtask

	task t_table;
		op_e t [4];
		logic [7:0] p;
		t = '{far_table_read_op, far_preinc_table_read_op, far_last_table_read_op,
			far_preinc_last_table_read_op};
		p = TP_RST;
		table_page <= 6'h05;
		for (int i = 0; i < 4; i++)
		begin
			if (i % 2 == 1)
				p++;
			run(t[i], 10'(10'h1F0 + i), 1'b0);
			chk(16'(n), 16'd3, "table cycles");
			chk(table_high_byte, (i > 1) ? 8'h3F : 8'h05, "table page");
			chk(u_mem.ram[10'(10'h1F0 + i)], p, "table low");
		end
	endtask

	task t_ctrl;
		run(op_mov_st, PC_LOW_ADDR, 1'b0);
		chk(16'(n), 16'd3, "low pc cycles");
		chk(pc[7:0], 8'h9A, "low pc value");
		pc0 = pc;
		call_target <= 14'h1234;
		run(op_call, 10'h000, 1'b0);
		chk(16'(n), 16'd2, "call cycles");
		chk(u_mem.top, pc0 + 14'd1, "call push");
		chk(pc, 14'h1234, "call target");
		chk(status, 8'h12, "call flags");
	endtask

	task t_clr;
		u_mem.ram[10'h3FF] = 8'hFF;
		run(op_clr, 10'h3FF, 1'b0);
		chk(u_mem.ram[10'h3FF], 8'h00, "clear");
		u_mem.ram[10'h200] = 8'hFF;
		issue_bit <= 3'h3;
		run(op_bit_clr, 10'h200, 1'b0);
		chk(u_mem.ram[10'h200], 8'hF7, "bit clear");
		chk(status, 8'h12, "clear flags");
	endtask

	task t_wdt;
		@(posedge clock);
		wdt_timeout <= 1'b1;
		power_down_set <= 1'b1;
		@(posedge clock);
		wdt_timeout <= 1'b0;
		power_down_set <= 1'b0;
		#1;
		chk(status, 8'hD2, "watchdog set");
		wseen = 1'b0;
		run(op_wdt_clr, 10'h000, 1'b0);
		chk(status, 8'h12, "watchdog flags");
		chk(wseen, 1'b1, "watchdog clear");
	endtask

	task t_sub;
		load(10'h2C0, 8'h9A);
		run(op_sub, 10'h2C0, 1'b1);
		chk(acc, 8'h00, "sub result");
		chk(status, 8'h27, "sub flags");
		u_mem.ram[10'h2C1] = 8'h01;
		run(op_sbc, 10'h2C1, 1'b1);
		chk(acc, 8'hFF, "sbc result");
		chk(status, 8'h10, "sbc chain");
		u_mem.ram[10'h2C2] = 8'h01;
		run(op_rrc, 10'h2C2, 1'b0);
		chk(u_mem.ram[10'h2C2], 8'h00, "rrc memory");
		chk(status, 8'h12, "rrc carry only");
		u_mem.ram[10'h2C3] = 8'hFF;
		run(op_siz, 10'h2C3, 1'b0);
		chk({sk, 15'(n)}, 16'h8003, "siz skip");
		chk(u_mem.ram[10'h2C3], 8'h00, "siz write");
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		u_mem.ram[10'h000] = 8'h00;
		t_add;
		t_logic;
		t_daa;
		t_skip;
		t_table;
		t_ctrl;
		t_clr;
		t_wdt;
		t_sub;
		stop_test;
	end

	// Whole run needs about 140 cycles; allow 800
	initial
	begin
		#20000;
		bad_count++;
		stop_test;
	end
endmodule // mcu_extended_instr_exec_tb_top
